// >>> src/tpdo_map_od.sv
// holds: transmit mapping dictionary, profile object list, restricted-write guard
// assumes: controller accesses arrive as one-cycle requests synchronous to mclk_i
// Behaviour
// - table one resets two entries, status word
// - table one entry two is motor current
// - entries three, four thermal and malfunction, inactive
// - table two resets empty, all entries zero
// - table three read-only, always four entries
// - table three maps scanner words ascending
// - standard profile objects are recognised
// - restricted writes refused in states five, six
// - restricted write in state four goes two
// - payload never exceeds eight bytes while every counted entry length is 64 bits or less
// - object identifiers are eleven bits wide
// - warnings reported, state left unchanged
// - fault held until controller fault reset arrives with the error cause removed
`timescale 1ns/1ps
`default_nettype none
module tpdo_map_od
  import od_pkg::*;
(
  input  wire logic              mclk_i,        // system clock
  input  wire logic              reset_n_i,     // async reset, active low
  input  wire logic              req_i,         // access request pulse
  input  wire logic              wr_i,          // 1 write, 0 read
  input  wire logic [15:0]       idx_i,         // object index
  input  wire logic [7:0]        sub_i,         // subindex
  input  wire logic [31:0]       wdata_i,       // write data
  input  wire logic              rws_wr_i,      // write to a restricted_write_param
  input  wire logic [10:0]       cob_id_i,      // identifier of accessed object
  input  wire logic [1:0]        tx_sel_i,      // table used for frame build
  input  wire logic [2:0]        state_req_i,   // profile transition request code
  input  wire logic              warn_i,        // warning detected
  input  wire logic              fault_i,       // error detected
  input  wire logic              fault_rst_i,   // fault reset command
  input  wire logic              cause_gone_i,  // error cause removed
  output logic                   ack_o,         // answer pulse
  output logic [1:0]             ack_code_o,    // answer code
  output logic [31:0]            rdata_o,       // read data
  output logic                   rws_ok_o,      // restricted write accepted
  output od_pkg::op_state_t      state_o,       // operating state
  output logic                   warn_o,        // warning report
  output logic [3:0]             tx_bytes_o,    // payload length of built frame
  output logic [15:0]            tx_idx_o,      // first mapped index of frame
  output logic [10:0]            cob_id_o       // echoed identifier
);

  // table storage
  logic [7:0]  tx1_count_ff;
  logic [31:0] tx1_entry_ff [MAX_MAP_ENTRIES];
  logic [7:0]  tx2_count_ff;
  logic [31:0] tx2_entry_ff [MAX_MAP_ENTRIES];
  op_state_t   state_ff;
  op_state_t   nxt_state;
  logic        is_w1, is_w2;  // writes targeting a writable table
  logic        rws_block;     // restricted write blocked in this state
  logic [31:0] tx3_rom [MAX_MAP_ENTRIES];

  // fixed third table
  assign tx3_rom[0] = TX3_E1;
  assign tx3_rom[1] = TX3_E2;
  assign tx3_rom[2] = TX3_E3;
  assign tx3_rom[3] = TX3_E4;

  assign rws_block = (state_ff == ST_OP_ENABLED) || (state_ff == ST_QSTOP);
  assign is_w1 = req_i && wr_i && idx_i == TX1_MAP_IDX && sub_i <= 8'h04 && !(rws_wr_i && rws_block);
  assign is_w2 = req_i && wr_i && idx_i == TX2_MAP_IDX && sub_i <= 8'h04 && !(rws_wr_i && rws_block);

  // first table, writable with defaults
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx1_count_ff    <= TX1_COUNT_RST;
      tx1_entry_ff[0] <= TX1_E1_RST;
      tx1_entry_ff[1] <= TX1_E2_RST;
      tx1_entry_ff[2] <= TX1_E3_RST;
      tx1_entry_ff[3] <= TX1_E4_RST;
    end
    else if (is_w1)
    begin
      // count limited to four entries
      if (sub_i == 8'h00)
      begin
        if (wdata_i[7:0] <= 8'h04)
          tx1_count_ff <= wdata_i[7:0];
      end
      else
        tx1_entry_ff[sub_i[1:0] - 2'h1] <= wdata_i;
    end
  end

  // second table, empty after reset
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx2_count_ff <= TX2_COUNT_RST;
      for (int i = 0; i < MAX_MAP_ENTRIES; i++)
        tx2_entry_ff[i] <= TX2_E_RST;
    end
    else if (is_w2)
    begin
      if (sub_i == 8'h00)
      begin
        if (wdata_i[7:0] <= 8'h04)
          tx2_count_ff <= wdata_i[7:0];
      end
      else
        tx2_entry_ff[sub_i[1:0] - 2'h1] <= wdata_i;
    end
  end

  // read mux and answer code
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_o      <= 1'b0;
      ack_code_o <= ACK_OK;
      rdata_o    <= 32'h00000000;
      rws_ok_o   <= 1'b0;
      cob_id_o   <= 11'h000;
    end
    else
    begin
      ack_o    <= req_i;
      rws_ok_o <= req_i && wr_i && rws_wr_i && !rws_block;
      cob_id_o <= req_i ? cob_id_i : cob_id_o;
      if (!req_i)
        ack_code_o <= ACK_OK;
      else if (wr_i && rws_wr_i && rws_block)
        ack_code_o <= ACK_STATE;
      else if (idx_i == TX1_MAP_IDX || idx_i == TX2_MAP_IDX)
      begin
        // subindex range check
        ack_code_o <= (sub_i <= 8'h04) ? ACK_OK : ACK_NO_OBJ;
        if (!wr_i)
        begin
          if (sub_i == 8'h00)
            rdata_o <= {24'h000000, idx_i == TX1_MAP_IDX ? tx1_count_ff : tx2_count_ff};
          else if (sub_i <= 8'h04)
            rdata_o <= idx_i == TX1_MAP_IDX ? tx1_entry_ff[sub_i[1:0] - 2'h1]
                                            : tx2_entry_ff[sub_i[1:0] - 2'h1];
        end
      end
      else if (idx_i == TX3_MAP_IDX)
      begin
        // read-only table refuses writes
        if (wr_i)
          ack_code_o <= ACK_RO;
        else if (sub_i == 8'h00)
        begin
          ack_code_o <= ACK_OK;
          rdata_o    <= {24'h000000, TX3_COUNT};
        end
        else if (sub_i <= 8'h04)
        begin
          ack_code_o <= ACK_OK;
          rdata_o    <= tx3_rom[sub_i[1:0] - 2'h1];
        end
        else
          ack_code_o <= ACK_NO_OBJ;
      end
      else if (idx_i == ERR_CODE_IDX || idx_i == CTRL_WORD_IDX || idx_i == STAT_WORD_IDX
               || idx_i == QSTOP_OPT_IDX || idx_i == DIS_OPT_IDX || idx_i == OP_MODE_IDX
               || idx_i == MODE_DISP_IDX || idx_i == SUP_MODES_IDX)
      begin
        // profile objects known; status word reads the state
        ack_code_o <= ACK_OK;
        if (!wr_i)
          rdata_o <= (idx_i == STAT_WORD_IDX) ? {28'h0000000, state_ff} : 32'h00000000;
      end
      else
        ack_code_o <= ACK_NO_OBJ;
    end
  end

  // next operating state
  always_comb
  begin
    nxt_state = state_ff;
    if (state_ff == ST_FAULT)
    begin
      // leave fault only on reset after cause removed
      if (fault_rst_i && cause_gone_i)
        nxt_state = ST_SW_ON_DIS;
    end
    else if (fault_i)
      nxt_state = ST_FAULT;
    else if (req_i && wr_i && rws_wr_i && state_ff == ST_SWITCHED)
      nxt_state = ST_SW_ON_DIS;
    else
    begin
      case (state_req_i)
        3'h1: nxt_state = ST_READY;
        3'h2: nxt_state = ST_SWITCHED;
        3'h3: nxt_state = ST_OP_ENABLED;
        3'h4: nxt_state = ST_QSTOP;
        3'h5: nxt_state = ST_SW_ON_DIS;
        default: nxt_state = state_ff;
      endcase
    end
  end

  // state register; warning has no say in it
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_ff <= ST_SW_ON_DIS;
    else
      state_ff <= nxt_state;
  end
  assign state_o = state_ff;

  // warning report only
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      warn_o <= 1'b0;
    else
      warn_o <= warn_i;
  end

  // frame build from selected table
  logic [7:0]  sel_count;
  logic [31:0] sel_e [MAX_MAP_ENTRIES];
  logic [15:0] dec_idx  [MAX_MAP_ENTRIES];
  logic [7:0]  dec_bits [MAX_MAP_ENTRIES];
  logic [7:0]  sum_bits;

  always_comb
  begin
    sel_count = (tx_sel_i == 2'h0) ? tx1_count_ff : (tx_sel_i == 2'h1) ? tx2_count_ff : TX3_COUNT;
    for (int i = 0; i < MAX_MAP_ENTRIES; i++)
      sel_e[i] = (tx_sel_i == 2'h0) ? tx1_entry_ff[i] : (tx_sel_i == 2'h1) ? tx2_entry_ff[i] : tx3_rom[i];
  end

  // per-entry field decoders
  for (genvar g = 0; g < MAX_MAP_ENTRIES; g++)
  begin : g_dec
    map_entry_decode u_map_entry_decode (
      .entry_i    (sel_e[g]),
      .index_o    (dec_idx[g]),
      .subindex_o (),
      .bits_o     (dec_bits[g])
    );
  end

  // sum lengths of counted entries, skipping any entry of up to 64 bits that would take the sum past 64 bits
  always_comb
  begin
    sum_bits = 8'h00;
    for (int i = 0; i < MAX_MAP_ENTRIES; i++)
      if (8'(i) < sel_count && sum_bits <= 8'(MAX_PAYLOAD_BYTES * 8) - dec_bits[i])
        sum_bits = sum_bits + dec_bits[i];
  end

  // frame length capped at eight bytes for entry lengths up to 64 bits
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_bytes_o <= 4'h0;
      tx_idx_o   <= 16'h0000;
    end
    else
    begin
      tx_bytes_o <= sum_bits[6:3];
      tx_idx_o   <= (sel_count != 8'h00) ? dec_idx[0] : 16'h0000;
    end
  end

  // checks
  property p_fault_hold;
    @(posedge mclk_i) disable iff (!reset_n_i)
      state_ff == ST_FAULT && !(fault_rst_i && cause_gone_i) |=> state_ff == ST_FAULT;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault left without reset");

  property p_rws_block;
    @(posedge mclk_i) disable iff (!reset_n_i)
      req_i && wr_i && rws_wr_i && rws_block |=> ack_o && ack_code_o == ACK_STATE && !rws_ok_o;
  endproperty
  a_rws_block: assert property (p_rws_block) else $error("restricted write not refused");

  property p_rws_drop;
    @(posedge mclk_i) disable iff (!reset_n_i)
      req_i && wr_i && rws_wr_i && state_ff == ST_SWITCHED && !fault_i |=> state_ff == ST_SW_ON_DIS;
  endproperty
  a_rws_drop: assert property (p_rws_drop) else $error("switched-on write did not drop");

  property p_payload;
    @(posedge mclk_i) disable iff (!reset_n_i) tx_bytes_o <= 4'h8;
  endproperty
  a_payload: assert property (p_payload) else $error("payload above eight bytes");

  property p_tx3_ro;
    @(posedge mclk_i) disable iff (!reset_n_i)
      req_i && wr_i && idx_i == TX3_MAP_IDX && !(rws_wr_i && rws_block) |=> ack_code_o == ACK_RO;
  endproperty
  a_tx3_ro: assert property (p_tx3_ro) else $error("fixed table write accepted");

  property p_tx3_read;
    @(posedge mclk_i) disable iff (!reset_n_i)
      req_i && !wr_i && idx_i == TX3_MAP_IDX && sub_i == 8'h04 |=> rdata_o == TX3_E4;
  endproperty
  a_tx3_read: assert property (p_tx3_read) else $error("fixed entry four wrong");

  property p_profile;
    @(posedge mclk_i) disable iff (!reset_n_i)
      req_i && !wr_i && idx_i == STAT_WORD_IDX |=> ack_code_o == ACK_OK && rdata_o[3:0] == $past(state_ff);
  endproperty
  a_profile: assert property (p_profile) else $error("status word read wrong");

  property p_empty;
    @(posedge mclk_i) disable iff (!reset_n_i)
      tx_sel_i == 2'h1 && tx2_count_ff == 8'h00 |=> tx_bytes_o == 4'h0 && tx_idx_o == 16'h0000;
  endproperty
  a_empty: assert property (p_empty) else $error("empty table built data");

  property p_count_wr;
    @(posedge mclk_i) disable iff (!reset_n_i)
      is_w1 && sub_i == 8'h00 && wdata_i[7:0] <= 8'h04 |=> tx1_count_ff == $past(wdata_i[7:0]);
  endproperty
  a_count_wr: assert property (p_count_wr) else $error("count write lost");
endmodule
`default_nettype wire

// >>> common/od_pkg.sv
// package: object-dictionary constants for the transmit mapping block
// assumes: included before any design file
package od_pkg;
  // dictionary indices of the three mapping tables
  localparam logic [15:0] TX1_MAP_IDX = 16'h1a00;
  localparam logic [15:0] TX2_MAP_IDX = 16'h1a01;
  localparam logic [15:0] TX3_MAP_IDX = 16'h1a02;
  // standard profile objects
  localparam logic [15:0] ERR_CODE_IDX  = 16'h603f;
  localparam logic [15:0] CTRL_WORD_IDX = 16'h6040;
  localparam logic [15:0] STAT_WORD_IDX = 16'h6041;
  localparam logic [15:0] QSTOP_OPT_IDX = 16'h605a;
  localparam logic [15:0] DIS_OPT_IDX   = 16'h605c;
  localparam logic [15:0] OP_MODE_IDX   = 16'h6060;
  localparam logic [15:0] MODE_DISP_IDX = 16'h6061;
  localparam logic [15:0] SUP_MODES_IDX = 16'h6502;
  // reset values and fixed third-table contents
  localparam logic [7:0]  TX1_COUNT_RST = 8'h02;
  localparam logic [31:0] TX1_E1_RST    = 32'h60410010;
  localparam logic [31:0] TX1_E2_RST    = 32'h20020510;
  localparam logic [31:0] TX1_E3_RST    = 32'h20421f10;
  localparam logic [31:0] TX1_E4_RST    = 32'h20380710;
  localparam logic [7:0]  TX2_COUNT_RST = 8'h00;
  localparam logic [31:0] TX2_E_RST     = 32'h00000000;
  localparam logic [7:0]  TX3_COUNT     = 8'h04;
  localparam logic [31:0] TX3_E1        = 32'h20612a10;
  localparam logic [31:0] TX3_E2        = 32'h20612b10;
  localparam logic [31:0] TX3_E3        = 32'h20612c10;
  localparam logic [31:0] TX3_E4        = 32'h20612d10;
  // link limits
  localparam int MAX_PAYLOAD_BYTES = 8;
  localparam int COB_ID_SPACE      = 2048;
  localparam int MAX_MAP_ENTRIES   = 4;
  // access answers
  localparam logic [1:0] ACK_OK      = 2'h0;
  localparam logic [1:0] ACK_NO_OBJ  = 2'h1;
  localparam logic [1:0] ACK_RO      = 2'h2;
  localparam logic [1:0] ACK_STATE   = 2'h3;
  // operating states of the drive profile
  typedef enum logic [3:0] {
    ST_NOT_READY  = 4'h1,
    ST_SW_ON_DIS  = 4'h2,
    ST_READY      = 4'h3,
    ST_SWITCHED   = 4'h4,
    ST_OP_ENABLED = 4'h5,
    ST_QSTOP      = 4'h6,
    ST_FAULT_REAC = 4'h7,
    ST_FAULT      = 4'h8
  } op_state_t;
endpackage

// >>> src/map_entry_decode.sv
// holds: split of one 32-bit mapping entry into index, subindex, length
// assumes: purely combinational use inside the dictionary block
`timescale 1ns/1ps
`default_nettype none
module map_entry_decode (
  input  wire logic [31:0] entry_i,     // raw mapping entry
  output logic      [15:0] index_o,     // object index
  output logic      [7:0]  subindex_o,  // object subindex
  output logic      [7:0]  bits_o       // length in bits
);
  // field split of the entry
  assign index_o    = entry_i[31:16];
  assign subindex_o = entry_i[15:8];
  assign bits_o     = entry_i[7:0];
endmodule
`default_nettype wire

// >>> test/od_ctrl_model.sv
// controller model: issues one-cycle dictionary accesses
// assumes: bench calls access(); clock comes from the bench
`timescale 1ns/1ps
`default_nettype none
module od_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [1:0]  code_i,
  input  wire logic [31:0] rdata_i,
  output logic             req_o,
  output logic             wr_o,
  output logic [15:0]      idx_o,
  output logic [7:0]       sub_o,
  output logic [31:0]      wdata_o,
  output logic             rws_o,
  output logic [10:0]      cob_o
);
  int n_to = 0; // answers that never came
  initial {req_o, wr_o, idx_o, sub_o, wdata_o, rws_o, cob_o} = '0;
  // one request pulse, then a bounded wait for the answer
  task automatic access(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                        input logic [31:0] wd, input logic rw, input logic [10:0] cb,
                        output logic [1:0] cd, output logic [31:0] rd);
    int i;
    @(negedge clk_i);
    {req_o, wr_o, idx_o, sub_o, wdata_o, rws_o, cob_o} = {1'b1, w, ix, sb, wd, rw, cb};
    @(negedge clk_i);
    req_o = 1'b0;
    // released qualifiers change, so a stale value is never trusted
    {idx_o, sub_o, wdata_o} = ~{idx_o, sub_o, wdata_o};
    for (i = 0; i < 4 && ack_i !== 1'b1; i++)
      @(negedge clk_i);
    if (ack_i !== 1'b1)
      n_to++;
    cd = code_i;
    rd = rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> test/tpdo_map_od_tb.sv
// self-checking bench for the transmit mapping dictionary
// assumes: od_pkg and the controller model compiled first
`timescale 1ns/1ps
`default_nettype none
module tpdo_map_od_tb;
  import od_pkg::*;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        req, wr, rws, ack, rws_ok, warn_in, warn_out, flt, frst, gone;
  logic [15:0] idx, tx_idx;
  logic [7:0]  sub, cnt;
  logic [31:0] wdata, rdata, rd;
  logic [10:0] cob, cob_out, cb;
  logic [1:0]  code, cd, tx_sel;
  logic [2:0]  st_req;
  logic [3:0]  tx_bytes;
  op_state_t   state;
  logic [31:0] tbl [3][5];
  logic [31:0] ent [4];
  logic [15:0] prof [8];
  int          n_fail = 0;
  int          n_checks = 0;
  always #5 mclk_i = ~mclk_i;
  od_ctrl_model u_od_ctrl_model (.clk_i(mclk_i), .ack_i(ack), .code_i(code), .rdata_i(rdata),
    .req_o(req), .wr_o(wr), .idx_o(idx), .sub_o(sub), .wdata_o(wdata), .rws_o(rws), .cob_o(cob));
  tpdo_map_od u_tpdo_map_od (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req), .wr_i(wr),
    .idx_i(idx), .sub_i(sub), .wdata_i(wdata), .rws_wr_i(rws), .cob_id_i(cob), .tx_sel_i(tx_sel),
    .state_req_i(st_req), .warn_i(warn_in), .fault_i(flt), .fault_rst_i(frst), .cause_gone_i(gone),
    .ack_o(ack), .ack_code_o(code), .rdata_o(rdata), .rws_ok_o(rws_ok), .state_o(state),
    .warn_o(warn_out), .tx_bytes_o(tx_bytes), .tx_idx_o(tx_idx), .cob_id_o(cob_out));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
      n_fail++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one access with a random identifier
  task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] wd, input logic rw);
    cb = 11'($urandom);
    u_od_ctrl_model.access(w, ix, sb, wd, rw, cb, cd, rd);
    if (u_od_ctrl_model.n_to != 0)
    begin
      n_fail++;
      end_sim();
    end
    chk(cob_out, cb, "echoed id");
  endtask
  // one transition request held for one edge
  task automatic step(input logic [2:0] c);
    @(negedge mclk_i);
    st_req = c;
    @(negedge mclk_i);
    st_req = 3'h0;
  endtask
  // payload bytes of counted entries, overflowing ones skipped
  function automatic logic [3:0] exp_bytes();
    int sum = 0;
    for (int k = 0; k < 4; k++)
      if (k < cnt && sum + ent[k][7:0] <= 64)
        sum += ent[k][7:0];
    return 4'(sum / 8);
  endfunction
  task automatic frame(input logic [1:0] s);
    @(negedge mclk_i);
    tx_sel = s;
    repeat (2) @(negedge mclk_i);
    chk(tx_bytes, exp_bytes(), "frame bytes");
    chk(tx_idx, cnt != 0 ? ent[0][31:16] : 16'h0, "frame index");
  endtask
  initial
  begin
    tx_sel = 2'h0;
    st_req = 3'h0;
    {warn_in, flt, frst, gone} = '0;
    void'($urandom(41));
    tbl = '{'{32'(TX1_COUNT_RST), TX1_E1_RST, TX1_E2_RST, TX1_E3_RST, TX1_E4_RST},
            '{32'(TX2_COUNT_RST), TX2_E_RST, TX2_E_RST, TX2_E_RST, TX2_E_RST},
            '{32'(TX3_COUNT), TX3_E1, TX3_E2, TX3_E3, TX3_E4}};
    prof = '{ERR_CODE_IDX, CTRL_WORD_IDX, STAT_WORD_IDX, QSTOP_OPT_IDX, DIS_OPT_IDX,
             OP_MODE_IDX, MODE_DISP_IDX, SUP_MODES_IDX};
    repeat (16) @(negedge mclk_i);
    reset_n_i = 1'b1;
    chk(state, ST_SW_ON_DIS, "reset state");
    // defaults, plus refused writes to the fixed table
    for (int t = 0; t < 3; t++)
      for (int s = 0; s < 5; s++)
      begin
        acc(1'b0, TX1_MAP_IDX + 16'(t), 8'(s), 32'h0, 1'b0);
        chk(rd, tbl[t][s], "default");
        if (t == 2)
        begin
          acc(1'b1, TX3_MAP_IDX, 8'(s), $urandom, 1'b0);
          chk(cd, ACK_RO, "ro write");
        end
      end
    // frames of the default tables, fixed table unchanged
    for (int t = 0; t < 3; t++)
    begin
      cnt = tbl[t][0][7:0];
      for (int k = 0; k < 4; k++)
        ent[k] = tbl[t][k + 1];
      frame(2'(t));
    end
    // all four entries of table one active, then an oversized count
    acc(1'b1, TX1_MAP_IDX, 8'h0, 32'h4, 1'b0);
    cnt = 8'h4;
    // expected entries are table one again, not the fixed table
    for (int k = 0; k < 4; k++)
      ent[k] = tbl[0][k + 1];
    frame(2'h0);
    acc(1'b1, TX1_MAP_IDX, 8'h0, 32'h5, 1'b0);
    acc(1'b0, TX1_MAP_IDX, 8'h0, 32'h0, 1'b0);
    chk(rd, 32'h4, "count kept");
    // random mappings of table two, first pass at the 64-bit edge
    for (int n = 0; n < 6; n++)
    begin
      cnt = n == 0 ? 8'h4 : 8'($urandom_range(4));
      for (int k = 0; k < 4; k++)
      begin
        ent[k] = {24'($urandom), n == 0 ? 8'h20 : 8'(8 * $urandom_range(4, 1))};
        acc(1'b1, TX2_MAP_IDX, 8'(k + 1), ent[k], 1'b0);
      end
      acc(1'b1, TX2_MAP_IDX, 8'h0, 32'(cnt), 1'b0);
      chk(cd, ACK_OK, "count write");
      for (int k = 0; k < 4; k++)
      begin
        acc(1'b0, TX2_MAP_IDX, 8'(k + 1), 32'h0, 1'b0);
        chk(rd, ent[k], "readback");
      end
      frame(2'h1);
    end
    // selector code three also builds the fixed table
    cnt = TX3_COUNT;
    for (int k = 0; k < 4; k++)
      ent[k] = tbl[2][k + 1];
    frame(2'h3);
    // profile objects and unknown places
    for (int p = 0; p < 8; p++)
    begin
      acc(1'b0, prof[p], 8'h0, 32'h0, 1'b0);
      chk(cd, ACK_OK, "profile");
      chk(rd, prof[p] == STAT_WORD_IDX ? 32'(ST_SW_ON_DIS) : 32'h0, "profile data");
    end
    acc(1'b0, 16'h1234, 8'h0, 32'h0, 1'b0);
    chk(cd, ACK_NO_OBJ, "unknown object");
    acc(1'b0, TX1_MAP_IDX, 8'h05, 32'h0, 1'b0);
    chk(cd, ACK_NO_OBJ, "bad subindex");
    // restricted writes against the operating state
    step(3'h1);
    step(3'h2);
    chk(state, ST_SWITCHED, "switched on");
    acc(1'b1, TX1_MAP_IDX, 8'h2, TX1_E2_RST, 1'b1);
    chk({cd, rws_ok}, {ACK_OK, 1'b1}, "rws accept");
    chk(state, ST_SW_ON_DIS, "rws to disabled");
    step(3'h1);
    step(3'h2);
    step(3'h3);
    for (int q = 0; q < 2; q++)
    begin
      acc(1'b1, TX1_MAP_IDX, 8'h2, 32'h11111110, 1'b1);
      chk({cd, rws_ok}, {ACK_STATE, 1'b0}, "rws refuse");
      chk(state, q ? ST_QSTOP : ST_OP_ENABLED, "state kept");
      step(q ? 3'h0 : 3'h4);
    end
    acc(1'b0, TX1_MAP_IDX, 8'h2, 32'h0, 1'b0);
    chk(rd, TX1_E2_RST, "nothing stored");
    // warning leaves the state, fault waits for reset and cause
    @(negedge mclk_i);
    warn_in = 1'b1;
    @(negedge mclk_i);
    warn_in = 1'b0;
    chk(warn_out, 1'b1, "warning");
    chk(state, ST_QSTOP, "warning state");
    flt = 1'b1;
    @(negedge mclk_i);
    {flt, frst} = 2'h1;
    repeat (3) @(negedge mclk_i);
    chk(state, ST_FAULT, "fault held");
    gone = 1'b1;
    @(negedge mclk_i);
    chk(state, ST_SW_ON_DIS, "fault cleared");
    // disable request code brings the state back down
    step(3'h1);
    chk(state, ST_READY, "ready again");
    step(3'h5);
    chk(state, ST_SW_ON_DIS, "disable request");
    end_sim();
  end
endmodule
`default_nettype wire
